/* sfp_device.sv */
// Device end of the framed serial port, with the shared sender, receiver and FIFO
// Behaviour
// - Open strap reads one, grounded reads zero
// - Capture straps at turn-on, then drop pull-ups
// - Idle line is mark, logic one
// - Pairs run two-wire each or four-wire jointly
// - Default rate 115200 bits per second
// - One zero start bit, eight data, no parity
// - Data bits go least significant first
// - Exactly one stop bit at mark
// - Release driver only after last stop bit
// - Frame-end byte before and after each message
// - Frame-end in message becomes escape, 0xDC
// - Escape in message becomes escape, 0xDD
// Assumes one 100 MHz clock and asynchronous active-low reset everywhere
`timescale 1ns/1ps

// Synchronous FIFO; registered ready and valid
module sfp_fifo
    import sfp_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = `SFP_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Pointer and fill level; DEPTH must be a power of two for the wrap
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            in_ready <= cnt_d != (AW+1)'(DEPTH);
            out_valid <= cnt_d != '0;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    assign out_data = mem[rd_q];
endmodule : sfp_fifo

// SLIP encoder feeding an 8N1 character sender
module sfp_slip_tx
    import sfp_pkg::*;
#(
    parameter int unsigned BAUD_DIV = `SFP_BAUD_DIV
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire logic in_last,
    output logic in_ready,
    output logic line_o,
    output logic line_oe
);
    sfp_tx_st_e st_q, st_d;
    logic busy_q, busy_d, last_q, last_d, rdy_d, line_d, oe_d, go;
    logic [9:0] sh_q, sh_d;
    logic [3:0] bit_q, bit_d;
    logic [`SFP_CNT_W-1:0] cnt_q, cnt_d;
    sfp_byte_t sub_q, sub_d, chr;

    // Bit timer runs while a character is out; the encoder picks the next one once free
    always_comb begin
        st_d = st_q;
        busy_d = busy_q;
        sh_d = sh_q;
        bit_d = bit_q;
        cnt_d = cnt_q;
        sub_d = sub_q;
        last_d = last_q;
        go = 1'b0;
        chr = 8'h00;
        if (busy_q) begin
            if (cnt_q == `SFP_CNT_W'(BAUD_DIV - 1)) begin
                cnt_d = '0;
                if (bit_q == 4'(`SFP_CHAR_BITS - 1)) begin
                    busy_d = 1'b0;
                end else begin
                    sh_d = {1'b1, sh_q[9:1]};
                    bit_d = bit_q + 4'h1;
                end
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end else begin
            unique case (st_q)
                TX_IDLE: begin
                    if (in_valid) begin
                        go = 1'b1;
                        chr = `SFP_FEND;
                        st_d = TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (in_valid && in_ready) begin
                        go = 1'b1;
                        last_d = in_last;
                        if (in_data == `SFP_FEND) begin
                            chr = `SFP_FESC;
                            sub_d = `SFP_TFEND;
                            st_d = TX_SUB;
                        end else if (in_data == `SFP_FESC) begin
                            chr = `SFP_FESC;
                            sub_d = `SFP_TFESC;
                            st_d = TX_SUB;
                        end else begin
                            chr = in_data;
                            st_d = in_last ? TX_CLOSE : TX_DATA;
                        end
                    end
                end
                TX_SUB: begin
                    go = 1'b1;
                    chr = sub_q;
                    st_d = last_q ? TX_CLOSE : TX_DATA;
                end
                TX_CLOSE: begin
                    go = 1'b1;
                    chr = `SFP_FEND;
                    st_d = TX_IDLE;
                end
            endcase
        end
        if (go) begin
            busy_d = 1'b1;
            sh_d = {1'b1, chr, 1'b0};
            bit_d = 4'h0;
            cnt_d = '0;
        end
        rdy_d = (st_d == TX_DATA) && !busy_d;
        line_d = busy_d ? sh_d[0] : 1'b1;
        oe_d = busy_d || (st_d != TX_IDLE);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= TX_IDLE;
            busy_q <= 1'b0;
            sh_q <= 10'h3FF;
            bit_q <= 4'h0;
            cnt_q <= '0;
            sub_q <= 8'h00;
            last_q <= 1'b0;
            in_ready <= 1'b0;
            line_o <= 1'b1;
            line_oe <= 1'b0;
        end else begin
            st_q <= st_d;
            busy_q <= busy_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            cnt_q <= cnt_d;
            sub_q <= sub_d;
            last_q <= last_d;
            in_ready <= rdy_d;
            line_o <= line_d;
            line_oe <= oe_d;
        end
    end
endmodule : sfp_slip_tx

// 8N1 character receiver and SLIP decoder; line must already be synchronised
module sfp_slip_rx
    import sfp_pkg::*;
#(
    parameter int unsigned BAUD_DIV = `SFP_BAUD_DIV
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic line_i,
    input wire logic mute,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    output logic out_err
);
    sfp_rxb_st_e rs_q, rs_d;
    sfp_dec_st_e ds_q, ds_d;
    logic [`SFP_CNT_W-1:0] cnt_q, cnt_d;
    logic [2:0] bit_q, bit_d;
    sfp_byte_t sh_q, sh_d, pend_q, pend_d, b, push_b, od_d;
    logic pv_q, pv_d, bv, ferr, push, ov_d, ol_d, oe_d;

    // Character framing, sampled mid-bit; then unstuffing with a one-byte holdback
    // so the closing delimiter can mark the final byte
    always_comb begin
        rs_d = rs_q;
        ds_d = ds_q;
        cnt_d = cnt_q + 1'b1;
        bit_d = bit_q;
        sh_d = sh_q;
        pend_d = pend_q;
        pv_d = pv_q;
        bv = 1'b0;
        ferr = 1'b0;
        b = sh_q;
        push = 1'b0;
        push_b = 8'h00;
        ov_d = 1'b0;
        od_d = out_data;
        ol_d = 1'b0;
        oe_d = 1'b0;
        unique case (rs_q)
            RXB_IDLE: begin
                cnt_d = '0;
                if (!mute && !line_i) begin
                    rs_d = RXB_START;
                end
            end
            RXB_START: begin
                if (cnt_q == `SFP_CNT_W'(BAUD_DIV / 2 - 1)) begin
                    cnt_d = '0;
                    bit_d = 3'h0;
                    rs_d = line_i ? RXB_IDLE : RXB_BITS;
                end
            end
            RXB_BITS: begin
                if (cnt_q == `SFP_CNT_W'(BAUD_DIV - 1)) begin
                    cnt_d = '0;
                    sh_d = {line_i, sh_q[7:1]};
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'(`SFP_DATA_BITS - 1)) begin
                        rs_d = RXB_STOP;
                    end
                end
            end
            RXB_STOP: begin
                if (cnt_q == `SFP_CNT_W'(BAUD_DIV - 1)) begin
                    bv = line_i;
                    ferr = !line_i;
                    rs_d = RXB_IDLE;
                end
            end
        endcase
        if (ferr) begin
            oe_d = 1'b1;
            pv_d = 1'b0;
            ds_d = DEC_HUNT;
        end else if (bv) begin
            unique case (ds_q)
                DEC_HUNT: begin
                    if (b == `SFP_FEND) begin
                        ds_d = DEC_DATA;
                    end
                end
                DEC_DATA: begin
                    if (b == `SFP_FEND) begin
                        ov_d = pv_q;
                        od_d = pv_q ? pend_q : out_data;
                        ol_d = pv_q;
                        pv_d = 1'b0;
                    end else if (b == `SFP_FESC) begin
                        ds_d = DEC_ESC;
                    end else begin
                        push = 1'b1;
                        push_b = b;
                    end
                end
                DEC_ESC: begin
                    if (b == `SFP_TFEND || b == `SFP_TFESC) begin
                        push = 1'b1;
                        push_b = (b == `SFP_TFEND) ? `SFP_FEND : `SFP_FESC;
                        ds_d = DEC_DATA;
                    end else begin
                        oe_d = 1'b1;
                        pv_d = 1'b0;
                        ds_d = (b == `SFP_FEND) ? DEC_DATA : DEC_HUNT;
                    end
                end
                default: begin
                    ds_d = DEC_HUNT;
                end
            endcase
        end
        if (push) begin
            ov_d = pv_q;
            od_d = pv_q ? pend_q : out_data;
            pend_d = push_b;
            pv_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rs_q <= RXB_IDLE;
            ds_q <= DEC_HUNT;
            cnt_q <= '0;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            pend_q <= 8'h00;
            pv_q <= 1'b0;
            out_valid <= 1'b0;
            out_data <= 8'h00;
            out_last <= 1'b0;
            out_err <= 1'b0;
        end else begin
            rs_q <= rs_d;
            ds_q <= ds_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            pend_q <= pend_d;
            pv_q <= pv_d;
            out_valid <= ov_d;
            out_data <= od_d;
            out_last <= ol_d;
            out_err <= oe_d;
        end
    end
endmodule : sfp_slip_rx

// Device end: strap capture, send FIFO, pair steering
module sfp_device
    import sfp_pkg::*;
#(
    parameter int unsigned BAUD_DIV = `SFP_BAUD_DIV,
    parameter int unsigned STRAP_CYC = `SFP_STRAP_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    sfp_link_if.device link,
    input wire logic [`SFP_ADDR_W-1:0] strap_in,
    output logic strap_pullup_en,
    output logic [`SFP_ADDR_W-1:0] node_addr,
    output logic addr_valid,
    input wire logic four_wire,
    input wire logic pair_sel,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_err
);
    logic [1:0] ln_s1_q, ln_s2_q, po_d, poe_d;
    logic [`SFP_ADDR_W-1:0] st_s1_q, st_s2_q, addr_d;
    logic [15:0] cap_q, cap_d;
    logic av_d, pu_d, f_valid, f_ready, f_last, s_o, s_oe, tp, rp;
    sfp_byte_t f_data;

    sfp_fifo #(.WIDTH(9), .DEPTH(`SFP_FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys), .rstn(rstn), .in_valid(tx_valid), .in_data({tx_last, tx_data}),
        .in_ready(tx_ready), .out_valid(f_valid), .out_data({f_last, f_data}),
        .out_ready(f_ready));

    sfp_slip_tx #(.BAUD_DIV(BAUD_DIV)) u_tx (
        .clk_sys(clk_sys), .rstn(rstn), .in_valid(f_valid), .in_data(f_data),
        .in_last(f_last), .in_ready(f_ready), .line_o(s_o), .line_oe(s_oe));

    // Own echo on a shared two-wire pair is ignored while driving
    sfp_slip_rx #(.BAUD_DIV(BAUD_DIV)) u_rx (
        .clk_sys(clk_sys), .rstn(rstn), .line_i(ln_s2_q[rp]),
        .mute(!four_wire && link.dev_oe[rp]), .out_valid(rx_valid), .out_data(rx_data),
        .out_last(rx_last), .out_err(rx_err));

    // Pair steering and strap capture window
    always_comb begin
        tp = sfp_tx_pair(four_wire, pair_sel, 1'b1);
        rp = sfp_rx_pair(four_wire, pair_sel, 1'b1);
        po_d = 2'h3;
        poe_d = 2'h0;
        po_d[tp] = s_o;
        poe_d[tp] = s_oe;
        cap_d = addr_valid ? cap_q : cap_q + 16'h1;
        av_d = addr_valid || (cap_q == 16'(STRAP_CYC - 1));
        addr_d = (addr_valid || !av_d) ? node_addr : st_s2_q;
        pu_d = !av_d;
    end

    // Straps and pairs arrive from pins; two stages before use
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ln_s1_q <= 2'h3;
            ln_s2_q <= 2'h3;
            st_s1_q <= '1;
            st_s2_q <= '1;
            cap_q <= 16'h0;
            addr_valid <= 1'b0;
            node_addr <= '1;
            strap_pullup_en <= 1'b1;
            link.dev_o <= 2'h3;
            link.dev_oe <= 2'h0;
        end else begin
            ln_s1_q <= link.line;
            ln_s2_q <= ln_s1_q;
            st_s1_q <= strap_in;
            st_s2_q <= st_s1_q;
            cap_q <= cap_d;
            addr_valid <= av_d;
            node_addr <= addr_d;
            strap_pullup_en <= pu_d;
            link.dev_o <= po_d;
            link.dev_oe <= poe_d;
        end
    end
endmodule : sfp_device

/* sfp_cfg.svh */
// Constants of the framed serial port: character timing, framing bytes, strap capture
// Assumes a 100 MHz system clock; included only by the package, the other design files rely on that
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

`define SFP_CLK_HZ 100000000
`define SFP_CLK_NS 10
`define SFP_BAUD_BPS 115200
`define SFP_BAUD_DIV (`SFP_CLK_HZ / `SFP_BAUD_BPS)
`define SFP_CNT_W 16
`define SFP_DATA_BITS 8
`define SFP_CHAR_BITS 10
`define SFP_FEND 8'hC0
`define SFP_FESC 8'hDB
`define SFP_TFEND 8'hDC
`define SFP_TFESC 8'hDD
`define SFP_FIFO_DEPTH 32
`define SFP_ADDR_W 3
`define SFP_STRAP_NS 1000
`define SFP_STRAP_CYC ((`SFP_STRAP_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)

`endif

/* sfp_pkg.sv */
// Types shared by both ends of the framed serial port
// Assumes sfp_cfg.svh is on the include path
`include "sfp_cfg.svh"

package sfp_pkg;
    typedef logic [7:0] sfp_byte_t;
    typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_SUB, TX_CLOSE} sfp_tx_st_e;
    typedef enum logic [1:0] {RXB_IDLE, RXB_START, RXB_BITS, RXB_STOP} sfp_rxb_st_e;
    typedef enum logic [1:0] {DEC_HUNT, DEC_DATA, DEC_ESC} sfp_dec_st_e;

    // Pair used for sending; four-wire splits the pairs, two-wire shares one
    function automatic logic sfp_tx_pair(input logic four_wire, input logic pair_sel,
                                         input logic is_dev);
        sfp_tx_pair = four_wire ? is_dev : pair_sel;
    endfunction : sfp_tx_pair

    // Pair used for receiving
    function automatic logic sfp_rx_pair(input logic four_wire, input logic pair_sel,
                                         input logic is_dev);
        sfp_rx_pair = four_wire ? !is_dev : pair_sel;
    endfunction : sfp_rx_pair
endpackage : sfp_pkg

/* sfp_link_if.sv */
// Two serial pairs joining the device end and the host end
// Each end drives value and enable per pair; the wire level is resolved here
`timescale 1ns/1ps

interface sfp_link_if;
    logic [1:0] dev_o;
    logic [1:0] dev_oe;
    logic [1:0] host_o;
    logic [1:0] host_oe;
    logic [1:0] line;

    // Undriven pair floats to mark; device wins if both drive
    assign line = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) | (~dev_oe & ~host_oe);

    modport device(output dev_o, output dev_oe, input line);
    modport host(output host_o, output host_oe, input line);
endinterface : sfp_link_if

/* sfp_host.sv */
// Host end of the framed serial port: flight-computer side sender and receiver
// Assumes sfp_device.sv compiled first for the shared sender and receiver
`timescale 1ns/1ps

module sfp_host
    import sfp_pkg::*;
#(
    parameter int unsigned BAUD_DIV = `SFP_BAUD_DIV
) (
    input wire logic clk_sys,
    input wire logic rstn,
    sfp_link_if.host link,
    input wire logic four_wire,
    input wire logic pair_sel,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_err
);
    logic [1:0] ln_s1_q, ln_s2_q, po_d, poe_d;
    logic s_o, s_oe, tp, rp;

    // Host keeps the same character and framing rules; no queue, caller is stalled
    sfp_slip_tx #(.BAUD_DIV(BAUD_DIV)) u_tx (
        .clk_sys(clk_sys), .rstn(rstn), .in_valid(tx_valid), .in_data(tx_data),
        .in_last(tx_last), .in_ready(tx_ready), .line_o(s_o), .line_oe(s_oe));

    sfp_slip_rx #(.BAUD_DIV(BAUD_DIV)) u_rx (
        .clk_sys(clk_sys), .rstn(rstn), .line_i(ln_s2_q[rp]),
        .mute(!four_wire && link.host_oe[rp]), .out_valid(rx_valid), .out_data(rx_data),
        .out_last(rx_last), .out_err(rx_err));

    // Mirror of the device mapping: in four-wire mode host sends on the first pair
    always_comb begin
        tp = sfp_tx_pair(four_wire, pair_sel, 1'b0);
        rp = sfp_rx_pair(four_wire, pair_sel, 1'b0);
        po_d = 2'h3;
        poe_d = 2'h0;
        po_d[tp] = s_o;
        poe_d[tp] = s_oe;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ln_s1_q <= 2'h3;
            ln_s2_q <= 2'h3;
            link.host_o <= 2'h3;
            link.host_oe <= 2'h0;
        end else begin
            ln_s1_q <= link.line;
            ln_s2_q <= ln_s1_q;
            link.host_o <= po_d;
            link.host_oe <= poe_d;
        end
    end
endmodule : sfp_host

/* sfp_link_assertions.sv */
// Checker for the two serial pairs between the device end and the host end
// Assumes instantiation beside the interface, with the BAUD_DIV the ends use
`timescale 1ns/1ps

module sfp_link_assertions #(
    parameter int unsigned BAUD_DIV = `SFP_BAUD_DIV
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [1:0] dev_o,
    input wire logic [1:0] dev_oe,
    input wire logic [1:0] host_o,
    input wire logic [1:0] host_oe,
    input wire logic [1:0] line
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // A frame opens with a start bit, never with a stray mark
    chk_host_start_low: assert property ($rose(host_oe[0]) |-> !host_o[0])
        else $error("host frame opened without a start bit");
    chk_dev_start_low: assert property ($rose(dev_oe[1]) |-> !dev_o[1])
        else $error("device frame opened without a start bit");
    // Driver lets go only once a whole stop bit at mark has gone by
    chk_host_release_stop: assert property ($fell(host_oe[0]) |->
        $past(host_o[0]) && $past(host_o[0], BAUD_DIV))
        else $error("host released the pair inside a character");
    chk_dev_release_stop: assert property ($fell(dev_oe[1]) |->
        $past(dev_o[1]) && $past(dev_o[1], BAUD_DIV))
        else $error("device released the pair inside a character");
    // Bits last a whole bit time, so no low level on the first pair or high level on the second is shorter than eight cycles here
    chk_low_bit_width: assert property ($fell(line[0]) |-> !line[0] [*8])
        else $error("short low bit on first pair");
    chk_high_bit_width: assert property ($rose(line[1]) |-> line[1] [*8])
        else $error("short high bit on second pair");
    // Half duplex: never two talkers on one pair
    chk_pairs_exclusive: assert property ((dev_oe & host_oe) == 2'h0)
        else $error("both ends drive the same pair");
    // The device takes the second pair over only from the idle mark level
    chk_idle_before_frame: assert property ($rose(dev_oe[1]) |-> $past(line[1]))
        else $error("device took over a pair that was not idle");
endmodule : sfp_link_assertions

/* tb_slip_framed_serial_port.sv */
// Self-checking bench: device and host ends joined, plus a device fed raw bytes
// Assumes the design files and the checker are compiled first
`timescale 1ns/1ps

module tb_slip_framed_serial_port;
    import sfp_pkg::*;
    localparam int unsigned B = 16;
    logic clk_sys, rstn, fw, ps, pull_en, addr_v, e_rv, e_rl, e_re;
    logic [2:0] straps, addr;
    logic d_tv, d_tl, d_rdy, d_rv, d_rl, d_re, h_tv, h_tl, h_rdy, h_rv, h_rl, h_re;
    logic [7:0] d_td, d_rd, h_td, h_rd, e_rd;
    logic [8:0] dq[$], hq[$], eq[$], wq0[$], wq1[$];
    int fails, n_tests, n_err_d, n_err_h, n_err_e, st;

    sfp_link_if link ();
    sfp_link_if link2 ();
    sfp_device #(.BAUD_DIV(B), .STRAP_CYC(4)) sfp_device_inst (.clk_sys(clk_sys),
        .rstn(rstn), .link(link), .strap_in(straps), .strap_pullup_en(pull_en),
        .node_addr(addr), .addr_valid(addr_v), .four_wire(fw), .pair_sel(ps),
        .tx_valid(d_tv), .tx_data(d_td), .tx_last(d_tl), .tx_ready(d_rdy),
        .rx_valid(d_rv), .rx_data(d_rd), .rx_last(d_rl), .rx_err(d_re));
    sfp_host #(.BAUD_DIV(B)) sfp_host_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link),
        .four_wire(fw), .pair_sel(ps), .tx_valid(h_tv), .tx_data(h_td), .tx_last(h_tl),
        .tx_ready(h_rdy), .rx_valid(h_rv), .rx_data(h_rd), .rx_last(h_rl), .rx_err(h_re));
    // Second device faces a bench driver that breaks the escape rule
    sfp_device #(.BAUD_DIV(B), .STRAP_CYC(4)) sfp_device_err_inst (.clk_sys(clk_sys),
        .rstn(rstn), .link(link2), .strap_in(straps), .strap_pullup_en(),
        .node_addr(), .addr_valid(), .four_wire(fw), .pair_sel(ps),
        .tx_valid(1'b0), .tx_data(8'h00), .tx_last(1'b0), .tx_ready(),
        .rx_valid(e_rv), .rx_data(e_rd), .rx_last(e_rl), .rx_err(e_re));
    sfp_link_assertions #(.BAUD_DIV(B)) sfp_link_assertions_inst (.clk_sys(clk_sys),
        .rstn(rstn), .dev_o(link.dev_o), .dev_oe(link.dev_oe), .host_o(link.host_o),
        .host_oe(link.host_oe), .line(link.line));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Gather delivered bytes and error pulses; receivers have no back-pressure
    always @(posedge clk_sys) begin
        if (d_rv === 1'b1) dq.push_back({d_rl, d_rd});
        if (h_rv === 1'b1) hq.push_back({h_rl, h_rd});
        if (e_rv === 1'b1) eq.push_back({e_rl, e_rd});
        if (d_re === 1'b1) n_err_d++;
        if (h_re === 1'b1) n_err_h++;
        if (e_re === 1'b1) n_err_e++;
    end

    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cmpq(input string what, input logic [8:0] seen[$], input logic [8:0] exp[$]);
        chk(what, 9'(seen.size()), 9'(exp.size()));
        foreach (exp[k]) chk(what, seen[k], exp[k]);
    endtask : cmpq

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // Decode characters seen on one pair; samples near mid bit
    task automatic watch(input int p);
        logic [7:0] b;
        forever begin
            @(posedge clk_sys);
            if (link.line[p] === 1'b0) begin
                repeat (B / 2) @(posedge clk_sys);
                chk("start bit", 9'(link.line[p]), 9'h000);
                for (int i = 0; i < 8; i++) begin
                    repeat (B) @(posedge clk_sys);
                    b[i] = link.line[p];
                end
                repeat (B) @(posedge clk_sys);
                chk("stop bit", 9'(link.line[p]), 9'h001);
                if (p == 0) wq0.push_back({1'b0, b});
                else wq1.push_back({1'b0, b});
            end
        end
    endtask : watch

    // Stream words {last, byte} into one end; counts words refused for at least one cycle
    task automatic send(input bit dev, input logic [8:0] w[$], output int stalls);
        int n;
        stalls = 0;
        foreach (w[k]) begin
            {d_tl, d_td} <= w[k];
            {h_tl, h_td} <= w[k];
            d_tv <= dev;
            h_tv <= !dev;
            for (n = 0; n < 3000; n++) begin
                @(posedge clk_sys);
                if ((dev ? d_rdy : h_rdy) === 1'b1) break;
            end
            if (n > 0) stalls++;
            if (n == 3000) begin
                chk("handshake wait", 9'h000, 9'h001);
                wrap_up();
            end
        end
        d_tv <= 1'b0;
        h_tv <= 1'b0;
    endtask : send

    // Wait until both ends let go of every pair
    task automatic settle();
        int n;
        repeat (B) @(posedge clk_sys);
        for (n = 0; n < 30000; n++) begin
            @(posedge clk_sys);
            if ((link.dev_oe | link.host_oe) === 2'h0) break;
        end
        if (n == 30000) begin
            chk("release wait", 9'h000, 9'h001);
            wrap_up();
        end
    endtask : settle

    // Raw character on the second link, start, data low bit first, stop
    task automatic raw(input logic [7:0] b);
        logic [9:0] bits;
        bits = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            link2.host_o[0] <= bits[i];
            repeat (B) @(posedge clk_sys);
        end
    endtask : raw

    task automatic t_straps();
        chk("pull-up before capture", 9'(pull_en), 9'h001);
        repeat (8) @(posedge clk_sys);
        chk("address", 9'(addr), 9'h005);
        chk("address valid", 9'(addr_v), 9'h001);
        chk("pull-up after capture", 9'(pull_en), 9'h000);
        @(posedge clk_sys) straps <= 3'h2;
        repeat (8) @(posedge clk_sys);
        chk("address held", 9'(addr), 9'h005);
    endtask : t_straps

    task automatic t_bad_escape();
        logic [7:0] seq[$];
        seq = '{8'hC0, 8'h41, 8'hDB, 8'h41, 8'h42, 8'hC0, 8'hC0, 8'h66, 8'hC0};
        link2.host_oe[0] <= 1'b1;
        foreach (seq[k]) raw(seq[k]);
        link2.host_oe[0] <= 1'b0;
        repeat (4 * B) @(posedge clk_sys);
        chk("escape errors", 9'(n_err_e), 9'h001);
        cmpq("after bad escape", eq, '{9'h166});
    endtask : t_bad_escape

    task automatic t_host_to_dev();
        send(1'b0, '{9'h0C0, 9'h0DB, 9'h155, 9'h17E}, st);
        settle();
        cmpq("device rx", dq, '{9'h0C0, 9'h0DB, 9'h155, 9'h17E});
        cmpq("first pair chars", wq0, '{9'h0C0, 9'h0DB, 9'h0DC, 9'h0DB, 9'h0DD, 9'h055,
            9'h0C0, 9'h0C0, 9'h07E, 9'h0C0});
        chk("device errors", 9'(n_err_d), 9'h000);
    endtask : t_host_to_dev

    // Overrun the send FIFO; the link drains one character per character time
    task automatic t_dev_fifo();
        logic [8:0] w[$];
        for (int i = 0; i < 40; i++) w.push_back({i == 39, 8'hC0 ^ 8'(i)});
        send(1'b1, w, st);
        chk("fifo refused", 9'(st > 0), 9'h001);
        settle();
        cmpq("host rx", hq, w);
        chk("host errors", 9'(n_err_h), 9'h000);
        chk("second pair chars", 9'(wq1.size()), 9'h02C);
        chk("opening delimiter", wq1[0], 9'h0C0);
        chk("escaped delimiter", wq1[2], 9'h0DC);
    endtask : t_dev_fifo

    task automatic t_two_wire();
        fw <= 1'b0;
        ps <= 1'b1;
        repeat (2) @(posedge clk_sys);
        dq.delete();
        hq.delete();
        wq1.delete();
        send(1'b0, '{9'h011, 9'h122}, st);
        settle();
        send(1'b1, '{9'h133}, st);
        settle();
        cmpq("shared pair device rx", dq, '{9'h011, 9'h122});
        cmpq("shared pair host rx", hq, '{9'h133});
        chk("shared pair chars", 9'(wq1.size()), 9'h007);
        chk("idle level", 9'(link.line), 9'h003);
    endtask : t_two_wire

    // Main sequence: reset for four cycles, then each scenario in turn
    initial begin
        rstn = 1'b0;
        fw = 1'b1;
        ps = 1'b0;
        straps = 3'h5;
        d_tv = 1'b0;
        h_tv = 1'b0;
        d_td = 8'h00;
        h_td = 8'h00;
        d_tl = 1'b0;
        h_tl = 1'b0;
        link2.host_o = 2'h3;
        link2.host_oe = 2'h0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        fork
            watch(0);
            watch(1);
        join_none
        t_straps();
        t_bad_escape();
        t_host_to_dev();
        t_dev_fifo();
        t_two_wire();
        wrap_up();
    end
endmodule : tb_slip_framed_serial_port
